// *** verilog/drs_sequencer.sv ***
`default_nettype none
module drs_sequencer (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic emergency_halt_input_i,
    input wire logic run_hold_terminal_i,
    input wire logic start_i,
    input wire logic jog_i,
    input wire logic hold_i,
    input wire logic thermal_ok_i,
    input wire logic reference_select_terminal_i,
    input wire logic stop_style_jumper_i,
    input wire logic bus_ready_i,
    input wire logic trip_i,
    input wire logic ramp_at_zero_i,
    input wire logic [15:0] speed_rpm_i,
    output logic enable_request_o,
    output logic run_contact_o,
    output logic zero_speed_o,
    output logic fault_output_o,
    output logic digital_mode_o,
    output logic reference_zero_o,
    output logic pulse_gen_zero_o,
    output logic decel_active_o,
    output logic contactor_o
);
    logic rst_a;
    logic rst_n;
    logic [drs_pkg::N_IN-1:0] raw;
    logic [drs_pkg::N_IN-1:0] clean;
    drs_pkg::drs_mode_t mode;
    drs_pkg::drs_mode_t next_mode;
    logic ramp_decel;
    logic next_ramp_decel;
    logic trip_seen;
    logic zs_allowed;

    // Reset release through two flip-flops.
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    // Gather the operator pins.
    assign raw[drs_pkg::IN_HALT] = emergency_halt_input_i;
    assign raw[drs_pkg::IN_RAMP] = run_hold_terminal_i;
    assign raw[drs_pkg::IN_START] = start_i;
    assign raw[drs_pkg::IN_JOG] = jog_i;
    assign raw[drs_pkg::IN_HOLD] = hold_i;
    assign raw[drs_pkg::IN_THERM] = thermal_ok_i;
    assign raw[drs_pkg::IN_DIG] = reference_select_terminal_i;

    // One synchroniser and debouncer per pin.
    genvar gi;
    generate
        for (gi = 0; gi < drs_pkg::N_IN; gi++)
        begin : g_sync
            drs_sync u_sync (
                .clk_sys_i(clk_sys_i),
                .rst_n(rst_n),
                .raw_i(raw[gi]),
                .clean_o(clean[gi])
            );
        end
    endgenerate

    // Named views of the clean inputs.
    wire halt_ok = clean[drs_pkg::IN_HALT];
    wire ramp_in = clean[drs_pkg::IN_RAMP];
    wire start_in = clean[drs_pkg::IN_START];
    wire jog_in = clean[drs_pkg::IN_JOG];
    wire hold_in = clean[drs_pkg::IN_HOLD];
    wire therm_ok = clean[drs_pkg::IN_THERM];
    wire dig_in = clean[drs_pkg::IN_DIG];
    // Both halt and thermal loss force the mode to off at once.
    wire kill = !halt_ok || !therm_ok;

    // Mode decision; halt or thermal loss is checked first of all.
    always_comb
    begin
        next_mode = mode;
        next_ramp_decel = ramp_decel;
        if (kill)
        begin
            next_mode = drs_pkg::DRS_OFF;
            next_ramp_decel = 1'b0;
        end
        else
        begin
            case (mode)
                drs_pkg::DRS_OFF:
                begin
                    next_ramp_decel = 1'b0;
                    if (start_in)
                        next_mode = drs_pkg::DRS_RUN;
                    else if (jog_in)
                        next_mode = drs_pkg::DRS_JOG;
                end
                drs_pkg::DRS_RUN:
                begin
                    // Jog has no effect here.
                    if (!start_in && !ramp_in)
                    begin
                        if (stop_style_jumper_i)
                        begin
                            next_mode = drs_pkg::DRS_RAMP;
                            next_ramp_decel = 1'b1;
                        end
                        else
                            next_mode = drs_pkg::DRS_OFF;
                    end
                end
                drs_pkg::DRS_JOG:
                begin
                    if (!jog_in)
                    begin
                        if (stop_style_jumper_i)
                        begin
                            next_mode = drs_pkg::DRS_RAMP;
                            next_ramp_decel = 1'b1;
                        end
                        else
                            next_mode = drs_pkg::DRS_OFF;
                    end
                end
                drs_pkg::DRS_RAMP:
                begin
                    // Only halt, thermal loss or reaching zero ends the ramp.
                    if (ramp_at_zero_i)
                    begin
                        next_mode = drs_pkg::DRS_OFF;
                        next_ramp_decel = 1'b0;
                    end
                end
                default:
                begin
                    next_mode = drs_pkg::DRS_OFF;
                    next_ramp_decel = 1'b0;
                end
            endcase
        end
    end

    // Mode and ramp flag registers.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode <= drs_pkg::DRS_OFF;
            ramp_decel <= 1'b0;
        end
        else
        begin
            mode <= next_mode;
            ramp_decel <= next_ramp_decel;
        end
    end

    // Trip latch: cleared only while bus-ready is low and no trip is present.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            trip_seen <= 1'b0;
        else if (trip_i)
            trip_seen <= 1'b1;
        else if (!bus_ready_i)
            trip_seen <= 1'b0;
    end

    wire active = next_mode != drs_pkg::DRS_OFF;
    assign zs_allowed = active;

    drs_zero_speed u_zs (
        .clk_sys_i(clk_sys_i),
        .rst_n(rst_n),
        .speed_rpm_i(speed_rpm_i),
        .allowed_i(zs_allowed),
        .zero_speed_o(zero_speed_o)
    );

    // Registered outputs.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_request_o <= 1'b0;
            run_contact_o <= 1'b0;
            fault_output_o <= 1'b0;
            digital_mode_o <= 1'b0;
            reference_zero_o <= 1'b0;
            pulse_gen_zero_o <= 1'b0;
            decel_active_o <= 1'b0;
            contactor_o <= 1'b0;
        end
        else
        begin
            enable_request_o <= active;
            // Run contact only in run; faults do not open it.
            run_contact_o <= next_mode == drs_pkg::DRS_RUN;
            fault_output_o <= bus_ready_i && !trip_i && !trip_seen;
            digital_mode_o <= dig_in;
            reference_zero_o <= next_ramp_decel && !dig_in;
            pulse_gen_zero_o <= active && hold_in;
            decel_active_o <= next_ramp_decel;
            // Contactor pulls in on start and drops only on halt.
            if (!halt_ok)
                contactor_o <= 1'b0;
            else if (start_in)
                contactor_o <= 1'b1;
        end
    end

    // Assertions.
    a_halt_blocks_enable: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n) !halt_ok |=> !enable_request_o)
        else $error("enable request stayed on after halt loss");
    a_thermal_blocks: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n) !therm_ok |=> !enable_request_o)
        else $error("enable stayed on with thermal open");
    a_jog_no_contact: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        mode == drs_pkg::DRS_JOG |-> !run_contact_o)
        else $error("run contact closed in jog");
    a_zero_speed_gate: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n) zero_speed_o |-> enable_request_o)
        else $error("zero speed on while disabled");
    a_jog_ignored_run: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        mode == drs_pkg::DRS_RUN |=> mode != drs_pkg::DRS_JOG)
        else $error("jog taken during run");
    a_ramp_only_halt: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        mode == drs_pkg::DRS_RAMP && halt_ok && therm_ok && !ramp_at_zero_i
        |=> mode == drs_pkg::DRS_RAMP)
        else $error("ramp stop left by other source");
    a_fault_on_trip: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n) trip_i |=> !fault_output_o)
        else $error("fault output on during trip");
    a_coast_no_jumper: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        mode == drs_pkg::DRS_JOG && !jog_in && !stop_style_jumper_i
        |=> mode == drs_pkg::DRS_OFF && !enable_request_o)
        else $error("jog release without jumper did not coast");
    a_contact_in_run: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n) run_contact_o |-> mode == drs_pkg::DRS_RUN)
        else $error("run contact closed outside run mode");
    a_jog_needs_input: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        mode == drs_pkg::DRS_JOG && !jog_in |=> mode != drs_pkg::DRS_JOG)
        else $error("jog kept without jog input");
    a_ramp_on_release: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        mode == drs_pkg::DRS_RUN && !kill && !start_in && !ramp_in
        && stop_style_jumper_i |=> mode == drs_pkg::DRS_RAMP
        && decel_active_o)
        else $error("ramp stop release did not start deceleration");
    a_hold_stays_on: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n) pulse_gen_zero_o |-> enable_request_o)
        else $error("hold zeroed the reference while disabled");
    a_ref_zero_analog: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        reference_zero_o |-> decel_active_o && !digital_mode_o)
        else $error("reference zeroed outside analog ramp stop");
    a_digital_select: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n) dig_in |=> digital_mode_o)
        else $error("digital mode not selected");
    a_zero_speed_on: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        zs_allowed && speed_rpm_i >= drs_pkg::ZS_ON_RPM |=> zero_speed_o)
        else $error("zero speed output missed the upper threshold");
    a_start_enters_run: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        mode == drs_pkg::DRS_OFF && start_in && !kill
        |=> mode == drs_pkg::DRS_RUN && enable_request_o)
        else $error("start did not enter run mode");
endmodule
`default_nettype wire

// *** verilog/drs_pkg.sv ***
`default_nettype none
// Shared constants of the drive run-mode sequencer.
package drs_pkg;
    // Clock rate and input debounce time.
    localparam int CLK_MHZ = 250;
    localparam int DEBOUNCE_US = 2;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    localparam int DB_W = 10;
    // Zero-speed thresholds in RPM, with hysteresis.
    localparam int SPEED_W = 16;
    localparam logic [15:0] ZS_ON_RPM = 16'h000a;
    localparam logic [15:0] ZS_OFF_RPM = 16'h0005;
    // Operator input count and positions.
    localparam int N_IN = 7;
    localparam int IN_HALT = 0;
    localparam int IN_RAMP = 1;
    localparam int IN_START = 2;
    localparam int IN_JOG = 3;
    localparam int IN_HOLD = 4;
    localparam int IN_THERM = 5;
    localparam int IN_DIG = 6;
    // Sequencer modes.
    typedef enum logic [2:0] {
        DRS_OFF = 3'b000,
        DRS_RUN = 3'b001,
        DRS_JOG = 3'b010,
        DRS_RAMP = 3'b011
    } drs_mode_t;
endpackage
`default_nettype wire

// *** verilog/drs_sync.sv ***
`default_nettype none
// Three-stage synchroniser with a debounce counter; a change counts once
// the second and third stages agree and stay stable for the debounce time.
module drs_sync (
    input wire logic clk_sys_i,
    input wire logic rst_n,
    input wire logic raw_i,
    output logic clean_o
);
    logic s1;
    logic s2;
    logic s3;
    logic [drs_pkg::DB_W-1:0] cnt;
    wire agree = (s2 == s3);
    wire differs = agree && (s3 != clean_o);

    // Synchroniser chain.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= raw_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Debounce: accept a new level after it has held long enough.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            clean_o <= 1'b0;
        end
        else if (!differs)
            cnt <= '0;
        else if (cnt == drs_pkg::DB_W'(drs_pkg::DEBOUNCE_CYC - 1))
        begin
            cnt <= '0;
            clean_o <= s3;
        end
        else
            cnt <= cnt + 1'b1;
    end
endmodule
`default_nettype wire

// *** verilog/drs_zero_speed.sv ***
`default_nettype none
// Zero-speed detector with on/off hysteresis, gated by mode and enable.
module drs_zero_speed (
    input wire logic clk_sys_i,
    input wire logic rst_n,
    input wire logic [15:0] speed_rpm_i,
    input wire logic allowed_i,
    output logic zero_speed_o
);
    wire rise = speed_rpm_i >= drs_pkg::ZS_ON_RPM;
    wire fall = speed_rpm_i <= drs_pkg::ZS_OFF_RPM;

    // Set at the upper threshold, clear at the lower one, forced off
    // outside active modes or when enable drops.
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            zero_speed_o <= 1'b0;
        else if (!allowed_i)
            zero_speed_o <= 1'b0;
        else if (rise)
            zero_speed_o <= 1'b1;
        else if (fall)
            zero_speed_o <= 1'b0;
    end
endmodule
`default_nettype wire

// *** dv/drs_operator_model.sv ***
`default_nettype none
// Operator panel and braking contactor on the far side of the sequencer.
// The panel relays re-time each command by one clock, as real contacts
// would change at an arbitrary point relative to the drive's clock.
module drs_operator_model (
    input wire logic clk_sys_i,
    input wire logic halt_cmd_i,
    input wire logic run_hold_cmd_i,
    input wire logic start_cmd_i,
    input wire logic jog_cmd_i,
    input wire logic hold_cmd_i,
    input wire logic thermal_cmd_i,
    input wire logic dig_cmd_i,
    input wire logic contactor_i,
    output logic [6:0] pins_o,
    output logic brake_open_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Panel contacts follow the commands one clock later.
    always_ff @(posedge clk_sys_i)
    begin
        pins_o <= {dig_cmd_i, thermal_cmd_i, hold_cmd_i, jog_cmd_i,
            start_cmd_i, run_hold_cmd_i, halt_cmd_i};
    end
    // Normally closed braking poles open while the coil is energized, so
    // they open on the clock that start pulls the contactor in and close only when halt drops it.
    assign brake_open_o = contactor_i;
endmodule
`default_nettype wire

// *** dv/drs_sequencer_tb_top.sv ***
`default_nettype none
// Self-checking bench for the run-mode sequencer.
module drs_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic halt = 1'b1;
    logic run_hold = 1'b1;
    logic start = 1'b0;
    logic jog = 1'b0;
    logic hold = 1'b0;
    logic thermal = 1'b1;
    logic dig = 1'b0;
    logic jumper = 1'b1;
    logic bus_ready = 1'b1;
    logic trip = 1'b0;
    logic at_zero = 1'b0;
    logic [15:0] speed = 16'h0000;
    logic [6:0] pins;
    logic brake_open;
    logic en, run_c, zs, fault, digm, refz, pgz, decel, cont;
    int n_fail = 0;
    int tests_run = 0;
    // The clock toggles every half period of 2 ns.
    always #2 clk_sys_i = ~clk_sys_i;
    drs_operator_model PANEL (.clk_sys_i(clk_sys_i), .halt_cmd_i(halt),
        .run_hold_cmd_i(run_hold), .start_cmd_i(start), .jog_cmd_i(jog),
        .hold_cmd_i(hold), .thermal_cmd_i(thermal), .dig_cmd_i(dig),
        .contactor_i(cont), .pins_o(pins), .brake_open_o(brake_open));
    drs_sequencer DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .emergency_halt_input_i(pins[0]), .run_hold_terminal_i(pins[1]),
        .start_i(pins[2]), .jog_i(pins[3]), .hold_i(pins[4]),
        .thermal_ok_i(pins[5]), .reference_select_terminal_i(pins[6]),
        .stop_style_jumper_i(jumper), .bus_ready_i(bus_ready),
        .trip_i(trip), .ramp_at_zero_i(at_zero), .speed_rpm_i(speed),
        .enable_request_o(en), .run_contact_o(run_c), .zero_speed_o(zs),
        .fault_output_o(fault), .digital_mode_o(digm),
        .reference_zero_o(refz), .pulse_gen_zero_o(pgz),
        .decel_active_o(decel), .contactor_o(cont));
    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Waits out synchroniser, debounce and output register, then steps off
    // the edge so the checks see settled values.
    task automatic settle();
        repeat (520) @(posedge clk_sys_i);
        #1;
    endtask
    // Waits a few cycles for the synchronous inputs to take effect.
    task automatic tick();
        repeat (4) @(posedge clk_sys_i);
        #1;
    endtask
    // Prints the verdict and ends the run.
    task automatic results();
        if (n_fail == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence of operator actions with expected outputs.
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        settle();
        check(16'(en), 16'h0000);
        check(16'(fault), 16'h0001);
        start = 1'b1;
        settle();
        check(16'(en), 16'h0001);
        check(16'(run_c), 16'h0001);
        check(16'(brake_open), 16'h0001);
        start = 1'b0;
        settle();
        check(16'(en), 16'h0001);
        jog = 1'b1;
        settle();
        check(16'(run_c), 16'h0001);
        jog = 1'b0;
        speed = 16'h000c;
        tick();
        check(16'(zs), 16'h0001);
        speed = 16'h0007;
        tick();
        check(16'(zs), 16'h0001);
        speed = 16'h0004;
        tick();
        check(16'(zs), 16'h0000);
        hold = 1'b1;
        settle();
        check(16'({pgz, en}), 16'h0003);
        hold = 1'b0;
        trip = 1'b1;
        tick();
        check(16'({fault, run_c}), 16'h0001);
        trip = 1'b0;
        bus_ready = 1'b0;
        tick();
        bus_ready = 1'b1;
        dig = 1'b1;
        settle();
        check(16'({fault, digm}), 16'h0003);
        dig = 1'b0;
        settle();
        check(16'({digm, pgz}), 16'h0000);
        run_hold = 1'b0;
        settle();
        check(16'({decel, refz, run_c, en}), 16'h000d);
        start = 1'b1;
        settle();
        check(16'(decel), 16'h0001);
        start = 1'b0;
        settle();
        check(16'(decel), 16'h0001);
        at_zero = 1'b1;
        tick();
        check(16'({cont, decel, en}), 16'h0004);
        at_zero = 1'b0;
        run_hold = 1'b1;
        jog = 1'b1;
        settle();
        check(16'({run_c, en}), 16'h0001);
        jumper = 1'b0;
        jog = 1'b0;
        settle();
        check(16'({decel, en}), 16'h0000);
        jumper = 1'b1;
        jog = 1'b1;
        settle();
        jog = 1'b0;
        speed = 16'h000c;
        settle();
        check(16'({zs, decel, en}), 16'h0007);
        halt = 1'b0;
        settle();
        check(16'({zs, cont, decel, en}), 16'h0000);
        check(16'(brake_open), 16'h0000);
        halt = 1'b1;
        start = 1'b1;
        settle();
        start = 1'b0;
        thermal = 1'b0;
        settle();
        check(16'(en), 16'h0000);
        results();
    end
endmodule
`default_nettype wire
